// >>> rtl/tg_timer.sv
// Gated 16-bit timer with AHB-Lite register access.
// How it works
// - Sync bypass set: external edges count directly, skipping the alignment stage.
// - Switching sync mode may drop or add one increment.
// - Counter byte reads always return a stable registered value.
// - Gating enabled: count on selected clock edges only while gate active.
// - Gate active when gate level equals the polarity bit.
// - Gate source: pin, eight-bit timer wrap, period match, tenth match.
// - Eight-bit timer wrap from FF to 00 makes an internal pulse.
// - Toggle mode: flip-flop toggles per rising gate edge; cleared when off.
// - Single pulse: arm, count during pulse, trailing edge clears arm.
// - Toggle plus single pulse measures one full gate cycle.
// - Gate level status readable, valid even with gating disabled.
// - Falling gate level status sets gate-event flag; may request interrupt.
// - Count wraps FFFF to 0000 and sets sticky overflow flag.
// - Overflow interrupt needs on, overflow, peripheral and global enables.
// - In sleep only asynchronous external counting runs; overflow wakes.
// - Wake continues code; interrupt taken only with global enable.
// - Count feeds capture register and compare match.
// - Special trigger clears count without overflow; software write wins.
// - Timer-on clear stops counting; set counts always or gated.
// - Clock select: instruction, system, pin or crystal, low-freq osc.
// - Writing either count byte clears the prescaler.
// - Clearing timer-on also clears the gate toggle flip-flop.
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`include "tg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tg_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic external_count_input,
    input wire logic osc_input,
    input wire logic low_freq_osc_input,
    input wire logic gate_pin,
    input wire logic [7:0] eight_bit_timer_value,
    input wire logic period_match,
    input wire logic tenth_match,
    input wire logic sleep_mode,
    input wire logic capture_event,
    input wire logic [15:0] compare_value,
    input wire logic special_trigger_enable,
    output logic [15:0] count_value,
    output logic [15:0] capture_value,
    output logic compare_match,
    output logic irq_req,
    output logic wake_req,
    output logic secondary_osc_run
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    tg_pkg::tg_bus_type bus_st_r;
    logic [7:0] addr_r;
    logic [7:0] tcon_r;
    logic [7:0] gcon_r;
    logic [15:0] count_r;
    logic ovf_flag_r;
    logic gev_flag_r;
    logic [1:0] ien_r;
    logic [1:0] icon_r;
    logic on;
    logic [1:0] ps;
    logic [1:0] cs;
    logic ge;
    logic spm;
    logic tm;
    logic arm_r;
    logic accept;
    logic wr_en;
    logic wr_lo;
    logic wr_hi;
    logic wr_cnt;
    logic [31:0] rd_val;

    assign on = tcon_r[`TG_B_ON];
    assign ps = tcon_r[`TG_PS_LO +: 2];
    assign cs = tcon_r[`TG_CS_LO +: 2];
    assign ge = gcon_r[`TG_B_GE];
    assign tm = gcon_r[`TG_B_TM];
    assign spm = gcon_r[`TG_B_SPM];

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Reads take one wait state so a read right behind a write sees it.
    assign accept = hsel && hready && htrans[1];
    assign hreadyout = (bus_st_r != tg_pkg::TG_RWAIT);
    assign hresp = 1'b0;
    assign wr_en = (bus_st_r == tg_pkg::TG_WDATA);
    assign wr_lo = wr_en && (addr_r == `TG_OFS_CNTL);
    assign wr_hi = wr_en && (addr_r == `TG_OFS_CNTH);
    assign wr_cnt = wr_lo || wr_hi;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_st_r <= tg_pkg::TG_IDLE;
            addr_r <= 8'h00;
        end
        else if (accept)
        begin
            addr_r <= haddr[7:0];
            bus_st_r <= hwrite ? tg_pkg::TG_WDATA : tg_pkg::TG_RWAIT;
        end
        else if (bus_st_r == tg_pkg::TG_RWAIT)
            bus_st_r <= tg_pkg::TG_RDATA;
        else
            bus_st_r <= tg_pkg::TG_IDLE;
    end

    logic gval;
    logic gval_r;

    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (addr_r)
            `TG_OFS_TCON: rd_val[7:0] = tcon_r;
            `TG_OFS_GCON: rd_val[7:0] = {gcon_r[7:4], arm_r, gval_r,
                                         gcon_r[1:0]};
            `TG_OFS_CNTL: rd_val[7:0] = count_r[7:0];
            `TG_OFS_CNTH: rd_val[7:0] = count_r[15:8];
            `TG_OFS_FLAG: rd_val[1:0] = {gev_flag_r, ovf_flag_r};
            `TG_OFS_IEN: rd_val[1:0] = ien_r;
            `TG_OFS_ICON: rd_val[1:0] = icon_r;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Count bytes come from the counter register, never mid-change.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (bus_st_r == tg_pkg::TG_RWAIT)
            hrdata <= rd_val;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tcon_r <= 8'h00;
            gcon_r <= 8'h00;
            ien_r <= 2'h0;
            icon_r <= 2'h0;
        end
        else if (wr_en)
        begin
            if (addr_r == `TG_OFS_TCON)
                tcon_r <= {hwdata[7:2], 1'b0, hwdata[0]};
            if (addr_r == `TG_OFS_GCON)
                gcon_r <= {hwdata[7:4], 2'b00, hwdata[1:0]};
            if (addr_r == `TG_OFS_IEN)
                ien_r <= hwdata[1:0];
            if (addr_r == `TG_OFS_ICON)
                icon_r <= hwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Clock sources and prescaler
    // ------------------------------------------------------------
    logic [3:0] pin_q;
    logic [2:0] pin_d_r;
    logic src_rise_dly_r;
    logic [1:0] ph_r;
    logic [2:0] pre_r;
    logic [2:0] pre_lim;
    logic src_rise;
    logic ext_tick;
    logic lfo_tick;
    logic tick;
    logic async_mode;
    logic pre_out;
    logic cnt_en;

    tg_sync #(.W(4)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({gate_pin, low_freq_osc_input, osc_input, external_count_input}),
        .q(pin_q)
    );

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_d_r <= 3'h0;
            src_rise_dly_r <= 1'b0;
            ph_r <= 2'h0;
        end
        else
        begin
            pin_d_r <= pin_q[2:0];
            src_rise_dly_r <= src_rise;
            ph_r <= ph_r + 2'h1;
        end
    end

    assign src_rise = tcon_r[`TG_B_OSC] ? (pin_q[1] && !pin_d_r[1])
                                        : (pin_q[0] && !pin_d_r[0]);
    // Synchronised mode adds an alignment stage; bypass skips it, so a
    // mode change can drop or repeat one edge.
    assign ext_tick = tcon_r[`TG_B_SYNC] ? src_rise
                                         : src_rise_dly_r;
    assign lfo_tick = pin_q[2] && !pin_d_r[2];
    assign async_mode = (cs == tg_pkg::TG_CS_EXT) && tcon_r[`TG_B_SYNC];

    always_comb
    begin
        unique case (cs)
            tg_pkg::TG_CS_INSTR: tick = (ph_r == `TG_PH_LAST);
            tg_pkg::TG_CS_SYS: tick = 1'b1;
            tg_pkg::TG_CS_EXT: tick = ext_tick;
            tg_pkg::TG_CS_LFO: tick = lfo_tick;
        endcase
    end

    assign pre_lim = 3'((4'h1 << ps) - 4'h1);
    assign pre_out = tick && (pre_r == pre_lim);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pre_r <= 3'h0;
        else if (wr_cnt)
            pre_r <= 3'h0;
        else if (tick)
            pre_r <= pre_out ? 3'h0 : pre_r + 3'h1;
    end

    // ------------------------------------------------------------
    // Gate
    // ------------------------------------------------------------
    logic [7:0] t0_prev_r;
    logic t0_wrap_r;
    logic gsrc;
    logic pol_lvl;
    logic pol_prev_r;
    logic tff_r;
    logic base;
    logic base_prev_r;
    logic base_fall;
    logic arm_wr;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            t0_prev_r <= 8'h00;
            t0_wrap_r <= 1'b0;
        end
        else
        begin
            t0_prev_r <= eight_bit_timer_value;
            t0_wrap_r <= (t0_prev_r == `TG_T0_MAX) &&
                         (eight_bit_timer_value == `TG_T0_ZERO);
        end
    end

    always_comb
    begin
        unique case (gcon_r[`TG_B_GSS_LO +: 2])
            tg_pkg::TG_GS_PIN: gsrc = pin_q[3];
            tg_pkg::TG_GS_T0: gsrc = t0_wrap_r;
            tg_pkg::TG_GS_PER: gsrc = period_match;
            tg_pkg::TG_GS_TEN: gsrc = tenth_match;
        endcase
    end

    assign pol_lvl = (gsrc == gcon_r[`TG_B_POL]);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pol_prev_r <= 1'b0;
            tff_r <= 1'b0;
        end
        else
        begin
            pol_prev_r <= pol_lvl;
            if (!tm || !on)
                tff_r <= 1'b0;
            else if (pol_lvl && !pol_prev_r)
                tff_r <= !tff_r;
        end
    end

    // Toggle output feeds the single-pulse stage, so both together
    // span one whole source period.
    assign base = tm ? tff_r : pol_lvl;
    assign base_fall = base_prev_r && !base;
    assign arm_wr = wr_en && (addr_r == `TG_OFS_GCON);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            base_prev_r <= 1'b0;
            arm_r <= 1'b0;
        end
        else
        begin
            base_prev_r <= base;
            if (arm_wr)
                arm_r <= hwdata[`TG_B_ARM];
            else if (spm && base_fall)
                arm_r <= 1'b0;
        end
    end

    assign gval = spm ? (arm_r && base && base_prev_r) : base;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            gval_r <= 1'b0;
        else
            gval_r <= gval;
    end

    // ------------------------------------------------------------
    // Counter, capture and compare
    // ------------------------------------------------------------
    logic match_prev_r;
    logic match_now;
    logic sp_clr;
    logic ovf;

    assign cnt_en = on && (!ge || gval) && pre_out &&
                    (!sleep_mode || async_mode);
    assign match_now = on && (count_r == compare_value);
    assign sp_clr = compare_match && special_trigger_enable;
    assign ovf = cnt_en && (count_r == `TG_CNT_MAX) && !wr_cnt && !sp_clr;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count_r <= `TG_CNT_ZERO;
        else if (wr_lo)
            count_r[7:0] <= hwdata[7:0];
        else if (wr_hi)
            count_r[15:8] <= hwdata[7:0];
        else if (sp_clr)
            count_r <= `TG_CNT_ZERO;
        else if (cnt_en)
            count_r <= count_r + 16'h0001;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            match_prev_r <= 1'b0;
            compare_match <= 1'b0;
            capture_value <= 16'h0000;
        end
        else
        begin
            match_prev_r <= match_now;
            compare_match <= match_now && !match_prev_r;
            if (capture_event)
                capture_value <= count_r;
        end
    end

    assign count_value = count_r;

    // ------------------------------------------------------------
    // Flags, interrupt and wake
    // ------------------------------------------------------------
    logic flag_wr;
    assign flag_wr = wr_en && (addr_r == `TG_OFS_FLAG);

    // Flags clear by writing one; a same-cycle event still sets them.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ovf_flag_r <= 1'b0;
            gev_flag_r <= 1'b0;
        end
        else
        begin
            if (ovf)
                ovf_flag_r <= 1'b1;
            else if (flag_wr && hwdata[`TG_B_OVF])
                ovf_flag_r <= 1'b0;
            if (gval_r && !gval)
                gev_flag_r <= 1'b1;
            else if (flag_wr && hwdata[`TG_B_GEV])
                gev_flag_r <= 1'b0;
        end
    end

    logic ovf_pend;
    logic gev_pend;
    assign ovf_pend = on && ien_r[`TG_B_OVF] && ovf_flag_r &&
                      icon_r[`TG_B_PERIPHERAL_IRQ_ENABLE];
    assign gev_pend = ien_r[`TG_B_GEV] && gev_flag_r && icon_r[`TG_B_PERIPHERAL_IRQ_ENABLE];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_req <= 1'b0;
            wake_req <= 1'b0;
            secondary_osc_run <= 1'b0;
        end
        else
        begin
            irq_req <= icon_r[`TG_B_GIE] &&
                       (ovf_pend || gev_pend);
            wake_req <= sleep_mode && ovf_pend;
            secondary_osc_run <= tcon_r[`TG_B_OSC];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_req;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_rd_answer;
        !hreadyout ##1 hreadyout && (hrdata == $past(rd_val));
    endsequence
    property p_read;
        s_rd_req |=> s_rd_answer;
    endproperty
    a_read: assert property (p_read)
        else $error("read answer timing wrong");

    property p_off_hold;
        !on && !wr_cnt && !sp_clr |=> count_r == $past(count_r);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("count moved while off");

    property p_gate_hold;
        on && ge && !gval && !wr_cnt && !sp_clr |=>
            count_r == $past(count_r);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("count moved with gate inactive");

    property p_wrap;
        ovf |=> count_r == `TG_CNT_ZERO && ovf_flag_r;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not set overflow");

    property p_sp_clr;
        sp_clr && !wr_cnt && !ovf_flag_r && !ovf |=>
            count_r == `TG_CNT_ZERO && !ovf_flag_r;
    endproperty
    a_sp_clr: assert property (p_sp_clr)
        else $error("special trigger clear wrong");

    property p_tff_clr;
        !tm || !on |=> !tff_r;
    endproperty
    a_tff_clr: assert property (p_tff_clr)
        else $error("toggle flop not held clear");

    property p_pre_clr;
        wr_cnt |=> pre_r == 3'h0;
    endproperty
    a_pre_clr: assert property (p_pre_clr)
        else $error("prescaler not cleared");

    property p_gev;
        gval_r && !gval |=> gev_flag_r;
    endproperty
    a_gev: assert property (p_gev)
        else $error("gate event flag missed");

    property p_arm_clr;
        spm && arm_r && base_fall && !arm_wr |=> !arm_r ##1 !gval_r;
    endproperty
    a_arm_clr: assert property (p_arm_clr)
        else $error("arm not cleared on trailing edge");

    property p_irq;
        ovf_pend && icon_r[`TG_B_GIE] |=> irq_req;
    endproperty
    a_irq: assert property (p_irq)
        else $error("overflow interrupt missing");

    property p_no_gie;
        !icon_r[`TG_B_GIE] |=> !irq_req;
    endproperty
    a_no_gie: assert property (p_no_gie)
        else $error("interrupt without global enable");
endmodule : tg_timer
`default_nettype wire

// >>> rtl/tg_map.svh
// Register offsets and bit positions of the gated 16-bit timer.
`ifndef TG_MAP_SVH
`define TG_MAP_SVH
`define TG_OFS_TCON 8'h00
`define TG_OFS_GCON 8'h04
`define TG_OFS_CNTL 8'h08
`define TG_OFS_CNTH 8'h0c
`define TG_OFS_FLAG 8'h10
`define TG_OFS_IEN 8'h14
`define TG_OFS_ICON 8'h18
`define TG_B_ON 0
`define TG_B_SYNC 2
`define TG_B_OSC 3
`define TG_PS_LO 4
`define TG_CS_LO 6
`define TG_B_GSS_LO 0
`define TG_B_GVAL 2
`define TG_B_ARM 3
`define TG_B_SPM 4
`define TG_B_TM 5
`define TG_B_POL 6
`define TG_B_GE 7
`define TG_B_OVF 0
`define TG_B_GEV 1
`define TG_B_PERIPHERAL_IRQ_ENABLE 0
`define TG_B_GIE 1
`define TG_CNT_MAX 16'hffff
`define TG_CNT_ZERO 16'h0000
`define TG_T0_MAX 8'hff
`define TG_T0_ZERO 8'h00
`define TG_PH_LAST 2'h3
`endif

// >>> rtl/tg_pkg.sv
// Types shared by the gated 16-bit timer.
`default_nettype none
package tg_pkg;
    typedef enum logic [3:0] {
        TG_IDLE = 4'b0001,
        TG_WDATA = 4'b0010,
        TG_RWAIT = 4'b0100,
        TG_RDATA = 4'b1000
    } tg_bus_type;
    typedef enum logic [1:0] {
        TG_CS_INSTR = 2'h0,
        TG_CS_SYS = 2'h1,
        TG_CS_EXT = 2'h2,
        TG_CS_LFO = 2'h3
    } tg_clksel_type;
    typedef enum logic [1:0] {
        TG_GS_PIN = 2'h0,
        TG_GS_T0 = 2'h1,
        TG_GS_PER = 2'h2,
        TG_GS_TEN = 2'h3
    } tg_gatesel_type;
endpackage : tg_pkg
`default_nettype wire

// >>> rtl/tg_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module tg_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : tg_sync
`default_nettype wire

// >>> sim/tg_ext_src.sv
// Model of the external count clock, oscillators and gate pin.
`timescale 1ns/1ps
`default_nettype none
module tg_ext_src #(
    parameter int HALF = 4
) (
    input wire logic hclk,
    input wire logic run,
    input wire logic gate_level,
    output logic ext_clk,
    output logic gate_out,
    output logic osc_out,
    output logic lfo_out,
    output logic [15:0] n_edges
);
    logic [7:0] fr = 8'h00;
    logic [7:0] ph = 8'h00;
    initial ext_clk = 1'b0;
    initial n_edges = 16'h0000;
    // ------------------------------------------------------------
    // Count clock
    // ------------------------------------------------------------
    // The count clock stands low between bursts, so a stop never
    // counts as a rising edge.
    always @(posedge hclk)
    begin
        fr <= fr + 8'h01;
        if (!run)
        begin
            ext_clk <= 1'b0;
            ph <= 8'h00;
        end
        else if (ph == 8'(HALF - 1))
        begin
            ph <= 8'h00;
            ext_clk <= !ext_clk;
            if (!ext_clk)
                n_edges <= n_edges + 16'h0001;
        end
        else
            ph <= ph + 8'h01;
    end
    assign gate_out = gate_level;
    assign osc_out = fr[1];
    assign lfo_out = fr[3];
endmodule : tg_ext_src
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking testbench of the gated 16-bit timer.
`include "tg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic ext_run = 1'b0;
    logic gate_lvl = 1'b0;
    logic cap_ev = 1'b0;
    logic ste = 1'b0;
    logic slp = 1'b0;
    logic [15:0] cmp = 16'h0000;
    logic [15:0] c0;
    logic [31:0] rd;
    int fail_count = 0;
    int n_compared = 0;
    wire logic hreadyout;
    wire logic [31:0] hrdata;
    wire logic [15:0] count_value;
    wire logic [15:0] capture_value;
    wire logic [15:0] n_edges;
    wire logic irq_req;
    wire logic wake;
    wire logic ext;
    wire logic gpin;
    wire logic osc;
    wire logic lfo;
    tg_ext_src i_src (.hclk(hclk), .run(ext_run), .gate_level(gate_lvl),
        .ext_clk(ext), .gate_out(gpin), .osc_out(osc), .lfo_out(lfo),
        .n_edges(n_edges));
    tg_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(), .hrdata(hrdata), .external_count_input(ext),
        .osc_input(osc), .low_freq_osc_input(lfo), .gate_pin(gpin),
        .eight_bit_timer_value(8'h00), .period_match(1'b0),
        .tenth_match(1'b0), .sleep_mode(slp), .capture_event(cap_ev),
        .compare_value(cmp), .special_trigger_enable(ste),
        .count_value(count_value), .capture_value(capture_value),
        .compare_match(), .irq_req(irq_req), .wake_req(wake),
        .secondary_osc_run());
    initial
    begin
        forever #25 hclk = ~hclk;
    end
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rg(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rg
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rg(`TG_OFS_TCON);
        chk(rd[15:0], 16'h0000);
        rg(8'h1c);
        chk(rd[15:0], 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_wrap;
        wr(`TG_OFS_CNTL, 8'hfe);
        wr(`TG_OFS_CNTH, 8'hff);
        wr(`TG_OFS_IEN, 8'h01);
        wr(`TG_OFS_ICON, 8'h01);
        wr(`TG_OFS_TCON, 8'h41);
        cyc(8);
        chk({15'h0, irq_req}, 16'h0000);
        rg(`TG_OFS_FLAG);
        chk({15'h0, rd[0]}, 16'h0001);
        chk({15'h0, count_value < 16'h0040}, 16'h0001);
        wr(`TG_OFS_ICON, 8'h03);
        cyc(2);
        chk({15'h0, irq_req}, 16'h0001);
        wr(`TG_OFS_TCON, 8'h00);
        cyc(4);
        rg(`TG_OFS_FLAG);
        chk({15'h0, rd[0]}, 16'h0001);
        wr(`TG_OFS_FLAG, 8'h01);
        cyc(2);
        chk({15'h0, irq_req}, 16'h0000);
        rg(`TG_OFS_FLAG);
        chk({15'h0, rd[0]}, 16'h0000);
        wr(`TG_OFS_ICON, 8'h00);
        $display("test wrap done");
    endtask : t_wrap
    // Toggle mode stays off, so polarity changes are safe here.
    task automatic t_gate;
        for (int p = 0; p < 2; p++)
        begin
            gate_lvl <= !p[0];
            wr(`TG_OFS_GCON, {1'b1, p[0], 6'h00});
            wr(`TG_OFS_TCON, 8'h41);
            cyc(6);
            wr(`TG_OFS_FLAG, 8'h03);
            c0 = count_value;
            cyc(10);
            chk(count_value, c0);
            gate_lvl <= p[0];
            cyc(6);
            chk({15'h0, count_value !== c0}, 16'h0001);
            rg(`TG_OFS_GCON);
            chk({15'h0, rd[2]}, 16'h0001);
            gate_lvl <= !p[0];
            cyc(6);
            rg(`TG_OFS_FLAG);
            chk({15'h0, rd[1]}, 16'h0001);
            wr(`TG_OFS_TCON, 8'h00);
        end
        wr(`TG_OFS_GCON, 8'h00);
        $display("test gate done");
    endtask : t_gate
    // Synchronised pass awake, bypass pass asleep.
    task automatic t_ext;
        for (int s = 0; s < 2; s++)
        begin
            wr(`TG_OFS_CNTL, 8'h00);
            wr(`TG_OFS_CNTH, 8'h00);
            wr(`TG_OFS_TCON, {5'h10, s[0], 2'h1});
            slp <= s[0];
            cyc(4);
            c0 = n_edges;
            ext_run <= 1'b1;
            cyc(80);
            ext_run <= 1'b0;
            cyc(8);
            chk(count_value, n_edges - c0);
            wr(`TG_OFS_TCON, 8'h00);
        end
        wr(`TG_OFS_TCON, 8'h01);
        c0 = count_value;
        cyc(20);
        chk(count_value, c0);
        wr(`TG_OFS_TCON, 8'h00);
        wr(`TG_OFS_CNTL, 8'hff);
        wr(`TG_OFS_CNTH, 8'hff);
        wr(`TG_OFS_IEN, 8'h01);
        wr(`TG_OFS_ICON, 8'h01);
        wr(`TG_OFS_TCON, 8'h85);
        ext_run <= 1'b1;
        cyc(24);
        ext_run <= 1'b0;
        cyc(8);
        chk({15'h0, wake}, 16'h0001);
        chk({15'h0, irq_req}, 16'h0000);
        slp <= 1'b0;
        wr(`TG_OFS_TCON, 8'h00);
        wr(`TG_OFS_FLAG, 8'h01);
        wr(`TG_OFS_ICON, 8'h00);
        c0 = count_value;
        ext_run <= 1'b1;
        cyc(40);
        ext_run <= 1'b0;
        cyc(8);
        chk(count_value, c0);
        $display("test external done");
    endtask : t_ext
    task automatic t_trig;
        wr(`TG_OFS_CNTL, 8'h34);
        wr(`TG_OFS_CNTH, 8'h12);
        cap_ev <= 1'b1;
        @(posedge hclk);
        cap_ev <= 1'b0;
        cyc(2);
        chk(capture_value, 16'h1234);
        rg(`TG_OFS_CNTL);
        chk(rd[15:0], 16'h0034);
        rg(`TG_OFS_CNTH);
        chk(rd[15:0], 16'h0012);
        wr(`TG_OFS_FLAG, 8'h03);
        wr(`TG_OFS_CNTL, 8'h00);
        wr(`TG_OFS_CNTH, 8'h00);
        cmp <= 16'h0005;
        ste <= 1'b1;
        wr(`TG_OFS_TCON, 8'h01);
        cyc(60);
        chk({15'h0, count_value <= 16'h0005}, 16'h0001);
        rg(`TG_OFS_FLAG);
        chk({15'h0, rd[0]}, 16'h0000);
        ste <= 1'b0;
        wr(`TG_OFS_TCON, 8'h00);
        $display("test trigger done");
    endtask : t_trig
    task automatic pulse;
        gate_lvl <= 1'b1;
        cyc(12);
        gate_lvl <= 1'b0;
        cyc(6);
    endtask : pulse
    // Polarity is set before toggle mode is switched on.
    task automatic t_pulse;
        wr(`TG_OFS_GCON, 8'hd0);
        wr(`TG_OFS_GCON, 8'hd8);
        wr(`TG_OFS_TCON, 8'h41);
        c0 = count_value;
        pulse;
        chk({15'h0, count_value != c0}, 16'h0001);
        rg(`TG_OFS_GCON);
        chk({15'h0, rd[3]}, 16'h0000);
        c0 = count_value;
        pulse;
        chk(count_value, c0);
        wr(`TG_OFS_GCON, 8'hf0);
        wr(`TG_OFS_GCON, 8'hf8);
        pulse;
        c0 = count_value;
        cyc(4);
        chk({15'h0, count_value != c0}, 16'h0001);
        pulse;
        rg(`TG_OFS_GCON);
        chk({15'h0, rd[3]}, 16'h0000);
        c0 = count_value;
        cyc(6);
        chk(count_value, c0);
        wr(`TG_OFS_GCON, 8'h00);
        wr(`TG_OFS_TCON, 8'h00);
        $display("test pulse done");
    endtask : t_pulse
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_wrap;
        t_gate;
        t_ext;
        t_trig;
        t_pulse;
        report_and_stop;
    end
    // The tests take about seven hundred cycles; this allows over fifty times.
    initial
    begin
        #2000000;
        fail_count++;
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
